// >>> design/ubf_core.sv
`timescale 1ns/1ps
// What this block does
// - The ninth data bit goes out on the line exactly as software supplied it.
// - Buffer-empty flag is high with an empty buffer, low while a character waits.
// - A data write clears buffer-empty; its request follows flag, enable and global enable.
// - Transmit-complete sets when the frame is out and no character waits.
// - Transmit-complete clears when its interrupt is taken or on a one written.
// - Transmit-complete request is raised with its enable and global enable.
// - With parity enabled a parity bit goes between last data bit and stop.
// - Transmit disable waits until shifter and buffer are empty, then frees the pin.
// - Receive enable hands the serial input pin to the receiver.
// - In synchronous mode bits are clocked by the external serial clock pin.
// - After a start bit, bits shift in up to the first stop; second ignored.
// - At the first stop bit the character moves into the receive buffer.
// - Unused upper data bits read as zero for short characters.
// - Ninth bit and error bits travel with each character; a read advances them.
// - Receive-complete reads one while unread characters remain, else zero.
// - Receive disable flushes the buffer and drops receive-complete.
// - Receive-complete request follows flag, enable and global enable.
// - Receive buffer holds two characters and a third waits behind it; a fourth is lost and the next character stored carries overrun.
// - Frame error is one when the first stop bit sampled low.
// - Frame is low start, data LSB first, optional parity, high stops.
// - Parity is the xor of the data bits, inverted for odd parity.
module ubf_core #(
	parameter int RX_DEPTH = ubf_pkg::RX_DEPTH_DOC
) (
	input  logic                       CLOCK,
	input  logic                       RST_B,
	input  logic [2:0]                 CHAR_SIZE_SELECT,
	input  logic                       PARITY_ENABLE_BIT,
	input  logic                       PARITY_ODD_SELECT,
	input  logic                       TWO_STOP_BITS,
	input  logic                       SYNC_MODE,
	input  logic                       TRANSMIT_ENABLE,
	input  logic                       RECEIVE_ENABLE,
	input  logic                       TX_BUFFER_EMPTY_IRQ_EN,
	input  logic                       TX_COMPLETE_IRQ_EN,
	input  logic                       RX_COMPLETE_IRQ_EN,
	input  logic                       GLOBAL_IRQ_EN,
	input  logic                       TX_NINTH_BIT,
	input  logic                       DATA_WR,
	input  logic [ubf_pkg::DATA_W-1:0] DATA_WR_VALUE,
	input  logic                       DATA_RD,
	input  logic                       TXC_CLEAR_WR,
	input  logic                       TXC_IRQ_ACK,
	input  logic                       TX_BIT_TICK,
	input  logic                       RX_BIT_TICK,
	input  logic                       RXD_PIN,
	input  logic                       EXT_SERIAL_CLOCK_PIN,
	output logic                       TXD_OUT,
	output logic                       TXD_OE,
	output logic                       RXD_OWNED,
	output logic                       TX_BUFFER_EMPTY_FLAG,
	output logic                       TX_COMPLETE_FLAG,
	output logic                       RX_COMPLETE_FLAG,
	output logic [ubf_pkg::DATA_W-1:0] RD_DATA,
	output logic                       RX_NINTH_BIT,
	output logic                       FRAME_ERROR_FLAG,
	output logic                       OVERRUN_FLAG,
	output logic                       PARITY_ERROR_FLAG,
	output logic                       TX_BUFFER_EMPTY_IRQ,
	output logic                       TX_COMPLETE_IRQ,
	output logic                       RX_COMPLETE_IRQ
);
	import ubf_pkg::*;

	if (RX_DEPTH < 2) begin : g_bad_depth
		$error("ubf_core needs RX_DEPTH >= 2");
	end

	// Pin synchronisers
	logic rxd_s1_reg, rxd_s2_reg;
	logic xck_s1_reg, xck_s2_reg, xck_s3_reg;
	logic tx_strobe, rx_strobe, rxd_bit;
	logic [3:0] nbits;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rxd_s1_reg <= LINE_IDLE;
			rxd_s2_reg <= LINE_IDLE;
			xck_s1_reg <= 1'h0;
			xck_s2_reg <= 1'h0;
			xck_s3_reg <= 1'h0;
		end else begin
			rxd_s1_reg <= RXD_PIN;
			rxd_s2_reg <= rxd_s1_reg;
			xck_s1_reg <= EXT_SERIAL_CLOCK_PIN;
			xck_s2_reg <= xck_s1_reg;
			xck_s3_reg <= xck_s2_reg;
		end
	end

	// Sample on rising, change on falling external clock edge
	assign rx_strobe = SYNC_MODE ? (xck_s2_reg & ~xck_s3_reg) : RX_BIT_TICK;
	assign tx_strobe = SYNC_MODE ? (~xck_s2_reg & xck_s3_reg) : TX_BIT_TICK;
	assign rxd_bit   = rxd_s2_reg;
	assign nbits     = ubf_char_bits(CHAR_SIZE_SELECT);

	// ---------------- Transmitter ----------------
	ubf_tx_state_t tx_state_reg;
	logic [8:0]    tx_buf_reg;
	logic          tx_buf_empty_reg;
	logic [8:0]    tx_shift_reg;
	logic [8:0]    tx_sent_reg;
	logic [3:0]    tx_cnt_reg;
	logic          tx_par_reg;
	logic          tx_en_eff_reg;
	logic          txd_reg;
	logic          txc_reg;
	logic          tx_frame_end;
	logic          tx_load;
	logic [3:0]    stop_cnt;

	assign stop_cnt     = TWO_STOP_BITS ? 4'h1 : 4'h0;
	assign tx_frame_end = tx_strobe & (tx_state_reg == TX_STOP) & (tx_cnt_reg == 4'h0);
	assign tx_load      = tx_en_eff_reg & ~tx_buf_empty_reg
		& ((tx_state_reg == TX_IDLE) | tx_frame_end);

	// Ninth bit sampled with the data byte
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			tx_buf_reg       <= '0;
			tx_buf_empty_reg <= RST_TXBE;
		end else if (DATA_WR) begin
			tx_buf_reg       <= {(CHAR_SIZE_SELECT == CSZ_NINE) & TX_NINTH_BIT,
				DATA_WR_VALUE};
			tx_buf_empty_reg <= 1'h0;
		end else if (tx_load) begin
			tx_buf_empty_reg <= 1'h1;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			tx_en_eff_reg <= 1'h0;
		end else if (TRANSMIT_ENABLE) begin
			tx_en_eff_reg <= 1'h1;
		end else if (tx_state_reg == TX_IDLE && tx_buf_empty_reg && !DATA_WR) begin
			tx_en_eff_reg <= 1'h0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= '0;
			tx_sent_reg  <= '0;
			tx_cnt_reg   <= '0;
			tx_par_reg   <= 1'h0;
			txd_reg      <= LINE_IDLE;
		end else if (tx_load) begin
			tx_state_reg <= TX_START;
			tx_shift_reg <= tx_buf_reg;
			tx_sent_reg  <= tx_buf_reg;
			tx_par_reg   <= ubf_parity(tx_buf_reg, nbits, PARITY_ODD_SELECT);
			txd_reg      <= 1'h0;
		end else if (tx_strobe) begin
			case (tx_state_reg)
				TX_START: begin
					tx_state_reg <= TX_DATA;
					txd_reg      <= tx_shift_reg[0];
					tx_shift_reg <= {1'h0, tx_shift_reg[8:1]};
					tx_cnt_reg   <= 4'(nbits - 4'h1);
				end
				TX_DATA: begin
					if (tx_cnt_reg != 4'h0) begin
						txd_reg      <= tx_shift_reg[0];
						tx_shift_reg <= {1'h0, tx_shift_reg[8:1]};
						tx_cnt_reg   <= 4'(tx_cnt_reg - 4'h1);
					end else if (PARITY_ENABLE_BIT) begin
						tx_state_reg <= TX_PAR;
						txd_reg      <= tx_par_reg;
					end else begin
						tx_state_reg <= TX_STOP;
						txd_reg      <= LINE_IDLE;
						tx_cnt_reg   <= stop_cnt;
					end
				end
				TX_PAR: begin
					tx_state_reg <= TX_STOP;
					txd_reg      <= LINE_IDLE;
					tx_cnt_reg   <= stop_cnt;
				end
				TX_STOP: begin
					if (tx_cnt_reg == 4'h0) begin
						tx_state_reg <= TX_IDLE;
					end else begin
						tx_cnt_reg <= 4'(tx_cnt_reg - 4'h1);
					end
				end
				default: begin
					tx_state_reg <= TX_IDLE;
					txd_reg      <= LINE_IDLE;
				end
			endcase
		end
	end

	// Completion wins over a clear in the same cycle
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			txc_reg <= RST_TXC;
		end else if (tx_frame_end && tx_buf_empty_reg) begin
			txc_reg <= 1'h1;
		end else if (TXC_CLEAR_WR || TXC_IRQ_ACK) begin
			txc_reg <= 1'h0;
		end
	end

	// ---------------- Receiver ----------------
	ubf_rx_state_t        rx_state_reg;
	logic [8:0]           rx_shift_reg;
	logic [3:0]           rx_cnt_reg;
	logic                 rx_par_bit_reg;
	logic [WORD_W-1:0]    hold_word_reg;
	logic                 hold_valid_reg;
	logic                 ovr_pend_reg;
	logic                 rx_start;
	logic                 rx_done;
	logic                 hold_free;
	logic [8:0]           rx_data9;
	logic                 rx_pe;
	logic [WORD_W-1:0]    rx_word;

	ubf_stream_if #(.W(WORD_W)) rx_in ();
	ubf_stream_if #(.W(WORD_W)) rx_out ();

	assign rx_start  = RECEIVE_ENABLE & rx_strobe & (rx_state_reg == RX_IDLE) & ~rxd_bit;
	assign rx_done   = RECEIVE_ENABLE & rx_strobe & (rx_state_reg == RX_STOP);
	assign hold_free = ~hold_valid_reg | rx_in.ready;
	assign rx_data9  = 9'(rx_shift_reg >> (4'h9 - nbits));
	assign rx_pe     = PARITY_ENABLE_BIT
		& (ubf_parity(rx_data9, nbits, PARITY_ODD_SELECT) != rx_par_bit_reg);
	assign rx_word   = {rx_data9[8], ~rxd_bit, ovr_pend_reg, rx_pe, rx_data9[7:0]};

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rx_state_reg   <= RX_IDLE;
			rx_shift_reg   <= '0;
			rx_cnt_reg     <= '0;
			rx_par_bit_reg <= 1'h0;
		end else if (!RECEIVE_ENABLE) begin
			rx_state_reg <= RX_IDLE;
		end else if (rx_strobe) begin
			case (rx_state_reg)
				RX_IDLE: begin
					if (!rxd_bit) begin
						rx_state_reg <= RX_DATA;
						rx_shift_reg <= '0;
						rx_cnt_reg   <= 4'(nbits - 4'h1);
					end
				end
				RX_DATA: begin
					rx_shift_reg <= {rxd_bit, rx_shift_reg[8:1]};
					if (rx_cnt_reg != 4'h0) begin
						rx_cnt_reg <= 4'(rx_cnt_reg - 4'h1);
					end else begin
						rx_state_reg <= PARITY_ENABLE_BIT ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: begin
					rx_par_bit_reg <= rxd_bit;
					rx_state_reg   <= RX_STOP;
				end
				RX_STOP: begin
					rx_state_reg <= RX_IDLE;
				end
				default: begin
					rx_state_reg <= RX_IDLE;
				end
			endcase
		end
	end

	// Completed frame waits here while the buffer is full
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			hold_word_reg  <= '0;
			hold_valid_reg <= 1'h0;
			ovr_pend_reg   <= 1'h0;
		end else if (!RECEIVE_ENABLE) begin
			hold_valid_reg <= 1'h0;
			ovr_pend_reg   <= 1'h0;
		end else if (rx_done && hold_free) begin
			hold_word_reg  <= rx_word;
			hold_valid_reg <= 1'h1;
			ovr_pend_reg   <= 1'h0;
		end else begin
			if (rx_done) begin
				ovr_pend_reg <= 1'h1;
			end
			if (rx_in.ready) begin
				hold_valid_reg <= 1'h0;
			end
		end
	end

	assign rx_in.valid  = hold_valid_reg;
	assign rx_in.data   = hold_word_reg;
	assign rx_out.ready = DATA_RD;

	ubf_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (RX_DEPTH)
	) u_rx_fifo (
		.clk   (CLOCK),
		.rst_b (RST_B),
		.flush (~RECEIVE_ENABLE),
		.in_s  (rx_in),
		.out_s (rx_out)
	);

	// ---------------- Registered outputs ----------------
	logic [WORD_W-1:0] rd_word_reg;
	logic              rxc_reg;
	logic              rx_own_reg;
	logic              tx_buffer_empty_flag_irq_reg, txc_irq_reg, rxc_irq_reg;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rd_word_reg <= '0;
			rxc_reg     <= RST_RXC;
			rx_own_reg  <= 1'h0;
		end else begin
			rd_word_reg <= rx_out.valid ? rx_out.data : '0;
			rxc_reg     <= rx_out.valid;
			rx_own_reg  <= RECEIVE_ENABLE;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			tx_buffer_empty_flag_irq_reg <= 1'h0;
			txc_irq_reg  <= 1'h0;
			rxc_irq_reg  <= 1'h0;
		end else begin
			tx_buffer_empty_flag_irq_reg <= tx_buf_empty_reg & TX_BUFFER_EMPTY_IRQ_EN & GLOBAL_IRQ_EN;
			txc_irq_reg  <= txc_reg & TX_COMPLETE_IRQ_EN & GLOBAL_IRQ_EN;
			rxc_irq_reg  <= rx_out.valid & RX_COMPLETE_IRQ_EN & GLOBAL_IRQ_EN;
		end
	end

	assign TXD_OUT              = txd_reg;
	assign TXD_OE               = tx_en_eff_reg;
	assign RXD_OWNED            = rx_own_reg;
	assign TX_BUFFER_EMPTY_FLAG = tx_buf_empty_reg;
	assign TX_COMPLETE_FLAG     = txc_reg;
	assign RX_COMPLETE_FLAG     = rxc_reg;
	assign RD_DATA              = rd_word_reg[DATA_W-1:0];
	assign RX_NINTH_BIT         = rd_word_reg[FLD_NINTH];
	assign FRAME_ERROR_FLAG     = rd_word_reg[FLD_FE];
	assign OVERRUN_FLAG         = rd_word_reg[FLD_DOR];
	assign PARITY_ERROR_FLAG    = rd_word_reg[FLD_PE];
	assign TX_BUFFER_EMPTY_IRQ  = tx_buffer_empty_flag_irq_reg;
	assign TX_COMPLETE_IRQ      = txc_irq_reg;
	assign RX_COMPLETE_IRQ      = rxc_irq_reg;

	// ---------------- Assertions ----------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	AST_WR_CLEARS_EMPTY: assert property (DATA_WR |=> !TX_BUFFER_EMPTY_FLAG)
		else $error("buffer-empty flag not cleared by a data write");
	AST_EMPTY_IRQ: assert property (TX_BUFFER_EMPTY_IRQ == $past(TX_BUFFER_EMPTY_FLAG
		&& TX_BUFFER_EMPTY_IRQ_EN && GLOBAL_IRQ_EN))
		else $error("buffer-empty request does not follow flag and enables");
	AST_IDLE_LOAD: assert property ((DATA_WR && tx_state_reg == TX_IDLE && tx_en_eff_reg
		&& TX_BUFFER_EMPTY_FLAG) ##1 !DATA_WR
		|=> (tx_state_reg == TX_START && TX_BUFFER_EMPTY_FLAG && !TXD_OUT))
		else $error("idle write not moved into the shifter");
	AST_TXC_SET: assert property (tx_frame_end && TX_BUFFER_EMPTY_FLAG
		|=> TX_COMPLETE_FLAG && tx_state_reg == TX_IDLE)
		else $error("transmit-complete not set at frame end");
	AST_TXC_CLEAR: assert property (TX_COMPLETE_FLAG && TXC_IRQ_ACK && !tx_frame_end
		|=> !TX_COMPLETE_FLAG)
		else $error("transmit-complete not cleared by interrupt acknowledge");
	AST_TX_DISABLE_DEFER: assert property (!TRANSMIT_ENABLE && !TX_BUFFER_EMPTY_FLAG
		&& TXD_OE |=> TXD_OE)
		else $error("transmitter released with a character pending");
	AST_PARITY_OUT: assert property (tx_state_reg == TX_PAR
		|-> TXD_OUT == ubf_parity(tx_sent_reg, nbits, PARITY_ODD_SELECT))
		else $error("parity bit on the line is wrong");
	AST_STOP_HIGH: assert property (tx_state_reg == TX_STOP |-> TXD_OUT)
		else $error("stop bit not high");
	AST_RX_FLUSH: assert property (!RECEIVE_ENABLE ##1 !RECEIVE_ENABLE
		|=> !RX_COMPLETE_FLAG && !RX_COMPLETE_IRQ)
		else $error("receive buffer not flushed on disable");
	AST_FRAME_ERR: assert property (rx_done && hold_free && !rxd_bit
		|=> hold_valid_reg && hold_word_reg[FLD_FE])
		else $error("frame error not stored with the character");
	AST_RXC_LEVEL: assert property (RECEIVE_ENABLE && rx_in.valid && rx_in.ready ##1 !DATA_RD
		|=> RX_COMPLETE_FLAG)
		else $error("receive-complete low with unread data");

	COV_TX_FRAME: cover property (tx_frame_end && !TX_BUFFER_EMPTY_FLAG);
	COV_RX_FRAME: cover property (rx_done && hold_free);
	COV_OVERRUN: cover property (rx_done && !hold_free);
	COV_RX_READ: cover property (DATA_RD && RX_COMPLETE_FLAG);

endmodule : ubf_core

// >>> design/ubf_fifo.sv
`timescale 1ns/1ps
module ubf_fifo #(
	parameter int WIDTH = ubf_pkg::WORD_W,
	parameter int DEPTH = ubf_pkg::FIFO_DEPTH
) (
	input logic         clk,
	input logic         rst_b,
	input logic         flush,
	ubf_stream_if.snk   in_s,
	ubf_stream_if.src   out_s
);
	import ubf_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (WIDTH < 1 || DEPTH < 2) begin : g_bad_param
		$error("ubf_fifo needs WIDTH >= 1 and DEPTH >= 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : bump

	assign in_s.ready  = (count_reg != CW'(DEPTH));
	assign out_s.valid = (count_reg != '0);
	assign out_s.data  = mem_reg[rd_ptr_reg];
	assign push        = in_s.valid & in_s.ready;
	assign pop         = out_s.valid & out_s.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_s.data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= bump(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= bump(rd_ptr_reg);
			end
			if (push && !pop) begin
				count_reg <= CW'(count_reg + 1'b1);
			end else if (pop && !push) begin
				count_reg <= CW'(count_reg - 1'b1);
			end
		end
	end

endmodule : ubf_fifo

// >>> pkg/ubf_pkg.sv
package ubf_pkg;

	localparam int DATA_W       = 8;
	localparam int WORD_W       = 12;
	localparam int FLD_PE       = 8;
	localparam int FLD_DOR      = 9;
	localparam int FLD_FE       = 10;
	localparam int FLD_NINTH    = 11;
	localparam int RX_DEPTH_DOC = 2;
	localparam int FIFO_DEPTH   = 8;

	localparam logic [2:0] CSZ_NINE  = 3'h7;
	localparam logic       RST_TXBE  = 1'h1;
	localparam logic       RST_TXC   = 1'h0;
	localparam logic       RST_RXC   = 1'h0;
	localparam logic       LINE_IDLE = 1'h1;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'h0,
		TX_START = 3'h1,
		TX_DATA  = 3'h3,
		TX_PAR   = 3'h2,
		TX_STOP  = 3'h6
	} ubf_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h0,
		RX_DATA = 2'h1,
		RX_PAR  = 2'h3,
		RX_STOP = 2'h2
	} ubf_rx_state_t;

	function automatic logic [3:0] ubf_char_bits(input logic [2:0] sel);
		case (sel)
			3'h0:     return 4'h5;
			3'h1:     return 4'h6;
			3'h2:     return 4'h7;
			CSZ_NINE: return 4'h9;
			default:  return 4'h8;
		endcase
	endfunction : ubf_char_bits

	function automatic logic ubf_parity(input logic [8:0] d, input logic [3:0] n,
			input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < n) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction : ubf_parity

endpackage : ubf_pkg

// >>> pkg/ubf_stream_if.sv
`timescale 1ns/1ps
interface ubf_stream_if #(parameter int W = 12);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : ubf_stream_if

// >>> verif/test_usart_buffer_flag_logic.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_usart_buffer_flag_logic;
	import ubf_pkg::*;
	logic CLOCK, RST_B, PARITY_ENABLE_BIT, PARITY_ODD_SELECT, TWO_STOP_BITS, SYNC_MODE;
	logic TRANSMIT_ENABLE, RECEIVE_ENABLE, TX_BUFFER_EMPTY_IRQ_EN, TX_COMPLETE_IRQ_EN;
	logic RX_COMPLETE_IRQ_EN, GLOBAL_IRQ_EN, TX_NINTH_BIT, DATA_WR, DATA_RD, TXC_CLEAR_WR;
	logic TXC_IRQ_ACK, TX_BIT_TICK, RX_BIT_TICK, RXD_PIN, EXT_SERIAL_CLOCK_PIN, TXD_OUT, TXD_OE;
	logic RXD_OWNED, TX_BUFFER_EMPTY_FLAG, TX_COMPLETE_FLAG, RX_COMPLETE_FLAG, RX_NINTH_BIT;
	logic FRAME_ERROR_FLAG, OVERRUN_FLAG, PARITY_ERROR_FLAG, TX_BUFFER_EMPTY_IRQ;
	logic TX_COMPLETE_IRQ, RX_COMPLETE_IRQ;
	logic [2:0]        CHAR_SIZE_SELECT;
	logic [DATA_W-1:0] DATA_WR_VALUE, RD_DATA;
	logic [1:0]        tick_cnt = 2'h0;
	logic [3:0]        frame_len = 4'ha;
	int                fails = 0;
	int                num_checks = 0;
	int                cycles = 0;

	ubf_core dut (.*);
	ubf_remote_xcvr rem (.clk(CLOCK), .rx_tick(TX_BIT_TICK), .tx_tick(TX_BIT_TICK),
		.txd(TXD_OUT), .txd_oe(TXD_OE), .frame_len(frame_len), .rxd(RXD_PIN));

	// Bit strobes every fourth cycle, the receive strobe only outside sync mode
	assign TX_BIT_TICK = (tick_cnt == 2'h3);
	assign RX_BIT_TICK = (tick_cnt == 2'h3) & ~SYNC_MODE;
	// External clock falls where the partner changes its line
	assign EXT_SERIAL_CLOCK_PIN = SYNC_MODE & tick_cnt[1];

	initial begin
		CLOCK = 1'h0;
		forever #5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		tick_cnt <= tick_cnt + 2'h1;
		cycles++;
		if (cycles > 5000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] v, input logic b9);
		DATA_WR = 1'h1;
		DATA_WR_VALUE = v;
		TX_NINTH_BIT = b9;
		cyc(1);
		DATA_WR = 1'h0;
		`CHK("buffer empty after write", 1'h0, TX_BUFFER_EMPTY_FLAG)
	endtask : wr
	task automatic wait_frames(input int n);
		for (int i = 0; i < 400 && rem.frames < n; i++) cyc(1);
		`CHK("frames seen", n, rem.frames)
	endtask : wait_frames
	task automatic rd(input logic [7:0] d, input logic fe, input logic ovr, input logic pe,
			input logic b9 = 1'h0);
		`CHK("rx complete", 1'h1, RX_COMPLETE_FLAG)
		`CHK("read data", d, RD_DATA)
		`CHK("rx ninth", b9, RX_NINTH_BIT)
		`CHK("frame error", fe, FRAME_ERROR_FLAG)
		`CHK("overrun", ovr, OVERRUN_FLAG)
		`CHK("parity error", pe, PARITY_ERROR_FLAG)
		DATA_RD = 1'h1;
		cyc(1);
		DATA_RD = 1'h0;
		cyc(1);
	endtask : rd

	task automatic t_tx8;
		`CHK("reset empty", 1'h1, TX_BUFFER_EMPTY_FLAG)
		`CHK("reset tx complete", 1'h0, TX_COMPLETE_FLAG)
		`CHK("reset rx complete", 1'h0, RX_COMPLETE_FLAG)
		{TRANSMIT_ENABLE, TX_COMPLETE_IRQ_EN, RX_COMPLETE_IRQ_EN, GLOBAL_IRQ_EN} = 4'hf;
		PARITY_ENABLE_BIT = 1'h1;
		cyc(2);
		wr(8'ha5, 1'h1);
		cyc(1);
		`CHK("moved to shifter", 1'h1, TX_BUFFER_EMPTY_FLAG)
		`CHK("start bit", 1'h0, TXD_OUT)
		`CHK("tx complete early", 1'h0, TX_COMPLETE_FLAG)
		wait_frames(1);
		`CHK("frame even", {2'h0, 1'h1, ^8'ha5, 8'ha5}, rem.last)
		cyc(1);
		`CHK("tx complete", 1'h1, TX_COMPLETE_FLAG)
		cyc(1);
		`CHK("tx complete irq", 1'h1, TX_COMPLETE_IRQ)
		TXC_IRQ_ACK = 1'h1;
		cyc(1);
		TXC_IRQ_ACK = 1'h0;
		`CHK("cleared by ack", 1'h0, TX_COMPLETE_FLAG)
		cyc(1);
		`CHK("tx complete irq off", 1'h0, TX_COMPLETE_IRQ)
	endtask : t_tx8

	task automatic t_tx9;
		CHAR_SIZE_SELECT = CSZ_NINE;
		{PARITY_ODD_SELECT, TWO_STOP_BITS, TX_BUFFER_EMPTY_IRQ_EN} = 3'h7;
		frame_len = 4'hb;
		cyc(2);
		`CHK("empty irq", 1'h1, TX_BUFFER_EMPTY_IRQ)
		wr(8'h3c, 1'h1);
		cyc(1);
		wr(8'hc3, 1'h0);
		cyc(2);
		`CHK("pending", 1'h0, TX_BUFFER_EMPTY_FLAG)
		`CHK("empty irq off", 1'h0, TX_BUFFER_EMPTY_IRQ)
		TRANSMIT_ENABLE = 1'h0;
		wait_frames(2);
		`CHK("ninth set", {1'h0, 1'h1, ~^9'h13c, 9'h13c}, rem.last)
		cyc(8);
		`CHK("no complete yet", 1'h0, TX_COMPLETE_FLAG)
		`CHK("pin held", 1'h1, TXD_OE)
		wait_frames(3);
		`CHK("ninth clear", {1'h0, 1'h1, ~^9'h0c3, 9'h0c3}, rem.last)
		`CHK("pin held last", 1'h1, TXD_OE)
		for (int i = 0; i < 20 && TXD_OE !== 1'h0; i++) cyc(1);
		`CHK("pin released", 1'h0, TXD_OE)
		`CHK("complete", 1'h1, TX_COMPLETE_FLAG)
		TXC_CLEAR_WR = 1'h1;
		cyc(1);
		TXC_CLEAR_WR = 1'h0;
		`CHK("cleared by write", 1'h0, TX_COMPLETE_FLAG)
	endtask : t_tx9

	task automatic t_rx;
		{CHAR_SIZE_SELECT, PARITY_ODD_SELECT, RECEIVE_ENABLE} = 5'h1;
		cyc(2);
		`CHK("pin owned", 1'h1, RXD_OWNED)
		rem.send(9'h15, 5, 1'h1, 1'h0, 1'h0, 1'h0);
		rem.send(9'h0a, 5, 1'h1, 1'h0, 1'h0, 1'h1);
		rem.send(9'h1f, 5, 1'h1, 1'h0, 1'h1, 1'h0);
		rem.send(9'h03, 5, 1'h1, 1'h0, 1'h0, 1'h0);
		cyc(4);
		`CHK("rx irq", 1'h1, RX_COMPLETE_IRQ)
		rd(8'h15, 1'h0, 1'h0, 1'h0);
		rd(8'h0a, 1'h1, 1'h0, 1'h0);
		rd(8'h1f, 1'h0, 1'h0, 1'h1);
		rem.send(9'h11, 5, 1'h1, 1'h0, 1'h0, 1'h0);
		cyc(4);
		rd(8'h11, 1'h0, 1'h1, 1'h0);
		cyc(2);
		`CHK("drained", 1'h0, RX_COMPLETE_FLAG)
		`CHK("rx irq off", 1'h0, RX_COMPLETE_IRQ)
		rem.send(9'h07, 5, 1'h1, 1'h0, 1'h0, 1'h0);
		cyc(4);
		`CHK("unread", 1'h1, RX_COMPLETE_FLAG)
		RECEIVE_ENABLE = 1'h0;
		cyc(3);
		`CHK("flushed", 1'h0, RX_COMPLETE_FLAG)
		`CHK("pin freed", 1'h0, RXD_OWNED)
	endtask : t_rx

	task automatic t_sync;
		{SYNC_MODE, RECEIVE_ENABLE} = 2'h3;
		CHAR_SIZE_SELECT = CSZ_NINE;
		cyc(4);
		rem.send(9'h1a5, 9, 1'h1, 1'h0, 1'h0, 1'h0);
		cyc(8);
		rd(8'ha5, 1'h0, 1'h0, 1'h0, 1'h1);
		`CHK("sync drained", 1'h0, RX_COMPLETE_FLAG)
	endtask : t_sync

	task automatic end_of_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		{PARITY_ENABLE_BIT, PARITY_ODD_SELECT, TWO_STOP_BITS, SYNC_MODE, TRANSMIT_ENABLE} = '0;
		{RECEIVE_ENABLE, TX_BUFFER_EMPTY_IRQ_EN, TX_COMPLETE_IRQ_EN, RX_COMPLETE_IRQ_EN} = '0;
		{GLOBAL_IRQ_EN, TX_NINTH_BIT, DATA_WR, DATA_RD, TXC_CLEAR_WR, TXC_IRQ_ACK} = '0;
		CHAR_SIZE_SELECT = 3'h3;
		DATA_WR_VALUE = 8'h00;
		RST_B = 1'h0;
		cyc(8);
		RST_B = 1'h1;
		cyc(1);
		t_tx8();
		t_tx9();
		t_rx();
		t_sync();
		end_of_test();
	end
endmodule : test_usart_buffer_flag_logic

// >>> verif/ubf_remote_xcvr.sv
`timescale 1ns/1ps
module ubf_remote_xcvr (
	input  wire logic       clk,
	input  wire logic       rx_tick,
	input  wire logic       tx_tick,
	input  wire logic       txd,
	input  wire logic       txd_oe,
	input  wire logic [3:0] frame_len,
	output logic            rxd
);
	logic        busy = 1'h0;
	logic [3:0]  cnt = 4'h0;
	logic [11:0] got = 12'h0;
	logic [11:0] last = 12'h0;
	int          frames = 0;
	initial rxd = 1'h1;
	// Bits after the start bit, LSB first, up to the first stop bit
	always @(posedge clk) begin
		if (tx_tick && txd_oe && busy) begin
			got[cnt] = txd;
			cnt = cnt + 4'h1;
			if (cnt == frame_len) begin
				busy = 1'h0;
				last = got;
				frames++;
			end
		end else if (tx_tick && txd_oe && !txd) begin
			busy = 1'h1;
			cnt = 4'h0;
			got = 12'h0;
		end
	end
	task automatic send(input logic [8:0] d, input int n, input logic par_en, input logic odd,
			input logic bad_par, input logic bad_stop);
		logic p;
		p = (^(d & 9'((1 << n) - 1))) ^ odd ^ bad_par;
		@(posedge clk iff rx_tick) rxd <= 1'h0;
		for (int i = 0; i < n; i++) @(posedge clk iff rx_tick) rxd <= d[i];
		if (par_en) @(posedge clk iff rx_tick) rxd <= p;
		@(posedge clk iff rx_tick) rxd <= ~bad_stop;
		@(posedge clk iff rx_tick) rxd <= 1'h1;
	endtask : send
endmodule : ubf_remote_xcvr
